// *** bench/cfecr_top_monitor.sv ***
`timescale 1ns/10ps
// ties the bank's outputs to the register writes that set them
module cfecr_top_monitor (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdata,
   input wire logic [4:0] slicerThresh,
   input wire logic       chanSel,
   input wire logic       bwHigh,
   input wire logic       coreSleep,
   input wire logic       priOe,
   input wire logic       secOe,
   input wire logic [2:0] outFormat,
   input wire logic [4:0] dataPinCnt,
   input wire logic       ddrRgb,
   input wire logic       blueSecondary,
   input wire logic       autoOffsetEn,
   input wire logic       offsetUpdate
);
   // one clock domain, all checks quiet during reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // read data stands only in the cycle after a read
   AST_RD_IDLE: assert property (!regRd |=> regRdata == 8'h00)
      else $error("read data not idle");
   AST_THRESH: assert property (
      regWr && regAddr == cfecr_pkg::OFF_SLICER
      |=> slicerThresh == $past(regWdata[7:3]))
      else $error("slicer threshold wrong");
   AST_BW: assert property (
      regWr && regAddr == cfecr_pkg::OFF_INPWR
      |=> bwHigh == $past(regWdata[5]))
      else $error("bandwidth wrong");
   AST_AO_EN: assert property (
      regWr && regAddr == cfecr_pkg::OFF_OFFSET
      |=> autoOffsetEn == $past(regWdata[5]))
      else $error("auto offset enable wrong");
   // derived outputs land two edges after the write
   AST_CHAN: assert property (
      regWr && regAddr == cfecr_pkg::OFF_INPWR && regWdata[7]
      |-> ##2 chanSel == $past(regWdata[6], 2))
      else $error("channel override ignored");
   AST_FMT: assert property (
      regWr && regAddr == cfecr_pkg::OFF_OUTFMT
      && regWdata[7:5] inside {3'h4, 3'h5, 3'h6}
      |-> ##2 outFormat == $past(regWdata[7:5], 2))
      else $error("output format wrong");
   AST_PINS: assert property (
      dataPinCnt == ((outFormat == cfecr_pkg::FMT_422)
      ? cfecr_pkg::PINS_422 : cfecr_pkg::PINS_FULL))
      else $error("data pin count wrong");
   AST_BLUE: assert property (
      blueSecondary == (outFormat != cfecr_pkg::FMT_444)
      && ddrRgb == (outFormat == cfecr_pkg::FMT_DDR))
      else $error("secondary or ddr flag wrong");
   // primary and secondary outputs never drive while the core sleeps
   AST_SLEEP: assert property (coreSleep |-> !priOe && !secOe)
      else $error("outputs on in power-down");
   // an update is a single pulse, only with the loop on
   AST_UPD: assert property (
      offsetUpdate |-> autoOffsetEn ##1 !offsetUpdate)
      else $error("bad offset update pulse");
endmodule // cfecr_top_monitor

bind cfecr_top cfecr_top_monitor i_mon (.sys_clk, .rst_n, .regAddr,
   .regWdata, .regWr, .regRd, .regRdata, .slicerThresh, .chanSel, .bwHigh,
   .coreSleep, .priOe, .secOe, .outFormat, .dataPinCnt, .ddrRgb,
   .blueSecondary, .autoOffsetEn, .offsetUpdate);

// *** bench/tb_cfecr_top.sv ***
`timescale 1ns/10ps
// self-checking bench for the capture front end control bank
module tb_cfecr_top;
   logic       sys_clk, rst_n, regWr, regRd;        // clock, reset, strobes
   logic [7:0] regAddr, regWdata, regRdata;         // register port
   logic [1:0] horizSyncInput, greenSyncInput;      // raw sync pins
   logic       powerDownPin, clampPulse, vsyncPulse; // pin and events
   logic       regenHsync, filtHsync;               // processed syncs
   logic       slicerOutputPin, slicerOutputPinOe;  // slicer pin
   logic [4:0] slicerThresh, dataPinCnt;            // fields out
   logic       chanSel, bwHigh, coreSleep, priOe, secOe;
   logic [2:0] outFormat;                           // format in force
   logic       ddrRgb, blueSecondary, autoOffsetEn, offsetUpdate;
   int         miscompares = 0;                     // mismatches
   int         checkCount  = 0;                     // comparisons
   int         cycles      = 0;                     // watchdog
   // power-up image of the five control registers
   logic [7:0] rstVal [5] = '{8'h5B, 8'hFF, 8'h78, 8'h20, 8'h94};

   cfecr_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .horizSyncInput(horizSyncInput),
      .greenSyncInput(greenSyncInput), .powerDownPin(powerDownPin),
      .clampPulse(clampPulse), .vsyncPulse(vsyncPulse),
      .regenHsync(regenHsync), .filtHsync(filtHsync),
      .slicerOutputPin(slicerOutputPin),
      .slicerOutputPinOe(slicerOutputPinOe), .slicerThresh(slicerThresh),
      .chanSel(chanSel), .bwHigh(bwHigh), .coreSleep(coreSleep),
      .priOe(priOe), .secOe(secOe), .outFormat(outFormat),
      .dataPinCnt(dataPinCnt), .ddrRgb(ddrRgb),
      .blueSecondary(blueSecondary), .autoOffsetEn(autoOffsetEn),
      .offsetUpdate(offsetUpdate));

   // 100 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // watchdog: the tests need some 2900 cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         miscompares++;
         results();
      end
   end

   // compare, count and report
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checkCount++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // wait edges, then let their updates land
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   // one-cycle read strobe, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask
   // print the counts and the verdict, then stop
   task automatic results();
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // power-up values, then write, read back, reserved places
   task automatic test_regs();
      for (int i = 0; i < 5; i++)
         rd(8'h1B + 8'(i), rstVal[i]);
      chk({slicerThresh, bwHigh, chanSel, secOe}, 8'h7C);
      chk({outFormat, dataPinCnt}, 8'h9E);
      for (int i = 0; i < 5; i++) begin
         wr(8'h1B + 8'(i), 8'hA5 ^ 8'(i));
         rd(8'h1B + 8'(i), 8'hA5 ^ 8'(i));
      end
      wr(8'h24, 8'hFF);
      rd(8'h24, 8'h00);
      wr(8'h00, 8'h55);
      rd(8'h00, 8'h00);
      // restore, fixed patterns included
      for (int i = 0; i < 5; i++) wr(8'h1B + 8'(i), rstVal[i]);
      $display("register test done");
   endtask

   // every source and polarity on the slicer pin
   task automatic test_slicer();
      logic lv;
      for (int s = 0; s < 4; s++) for (int p = 0; p < 2; p++)
         for (int l = 0; l < 2; l++) begin
            lv = l[0];
            wr(8'h1D, {5'h0F, p[0], s[1:0]});
            @(posedge sys_clk);
            {filtHsync, regenHsync, horizSyncInput[0], greenSyncInput[0]}
               <= (4'h1 << s) ^ {4{~lv}};
            wt(8);
            chk({7'h00, slicerOutputPin}, {7'h00, p[0] ? lv : ~lv});
         end
      $display("slicer test done");
   endtask

   // override, then automatic choice after activity on channel 1
   task automatic test_channel();
      wr(8'h1E, 8'hE0);
      wt(2);
      chk({7'h00, chanSel}, 8'h01);
      wr(8'h1E, 8'hA0);
      wt(2);
      chk({7'h00, chanSel}, 8'h00);
      wr(8'h1E, 8'h20);
      wt(1100);
      rd(8'h24, 8'h00);
      repeat (6) begin
         @(posedge sys_clk);
         horizSyncInput[1] <= ~horizSyncInput[1];
      end
      wt(8);
      rd(8'h24, 8'h40);
      chk({7'h00, chanSel}, 8'h01);
      $display("channel test done");
   endtask

   // table: register value, pin level, {sleep, primary, slicer oe}
   task automatic test_power();
      // first entry: automatic mode with channel 1 hsync still active
      logic [11:0] t [8] = '{12'h303, 12'h28D, 12'h29C, 12'h2B8,
                             12'h24D, 12'h243, 12'h205, 12'h20B};
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         powerDownPin <= t[i][3];
         wr(8'h1E, t[i][11:4]);
         wt(8);
         chk({5'h00, coreSleep, priOe, slicerOutputPinOe},
            {5'h00, t[i][2:0]});
      end
      wr(8'h1E, 8'h30);
      wt(1100);
      chk({6'h00, coreSleep, priOe}, 8'h02);
      repeat (6) begin
         @(posedge sys_clk);
         greenSyncInput[1] <= ~greenSyncInput[1];
      end
      wt(8);
      chk({6'h00, coreSleep, priOe}, 8'h01);
      wr(8'h1E, 8'h20);
      $display("power test done");
   endtask

   // each format code, both enables, then a reserved code
   task automatic test_format();
      for (int c = 4; c < 8; c++) begin
         wr(8'h1F, (c < 7) ? {c[2:0], 5'h18} : 8'h00);
         wt(2);
         chk({outFormat, dataPinCnt}, {(c < 7) ? c[2:0] : 3'h4,
            (c == 5) ? 5'h14 : 5'h1E});
         chk({4'h0, ddrRgb, blueSecondary, priOe, secOe},
            {4'h0, c == 6, c == 5 || c == 6, {2{c < 7}}});
      end
      $display("format test done");
   endtask

   // update interval for every code, and with the loop off
   task automatic test_offset();
      int n [4] = '{3, 48, 192, 3};
      int early;
      int late;
      for (int c = 0; c < 5; c++) begin
         wr(8'h1B, 8'h43);
         wr(8'h1B, {2'b01, c < 4, c[1:0], 3'b011});
         early = 0;
         late = 0;
         for (int k = 0; k < n[c[1:0]]; k++) begin
            @(posedge sys_clk);
            clampPulse <= (c != 3);
            vsyncPulse <= (c == 3);
            #1 early += offsetUpdate;
         end
         @(posedge sys_clk);
         clampPulse <= 1'b0;
         vsyncPulse <= 1'b0;
         repeat (4) begin
            #1 late += offsetUpdate;
            @(posedge sys_clk);
         end
         chk(8'(early), 8'h00);
         chk(8'(late), {7'h00, c < 4});
      end
      $display("offset test done");
   endtask

   // reset, then the scenarios in turn
   initial begin
      rst_n = 1'b0;
      {regWr, regRd, regAddr, regWdata} = 18'h00000;
      {horizSyncInput, greenSyncInput} = 4'h0;
      {clampPulse, vsyncPulse, regenHsync, filtHsync} = 4'h0;
      powerDownPin = 1'b1;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      wt(4);
      test_regs();
      test_slicer();
      test_channel();
      test_power();
      test_format();
      test_offset();
      results();
   end
endmodule // tb_cfecr_top

// *** hdl/cfecr_act_det.sv ***
`timescale 1ns/10ps
// per-pin activity detector for the sync inputs
module cfecr_act_det (
   input wire logic   sys_clk,
   input wire logic   rst_n,
   cfecr_act_if.det   act
);
   genvar i;
   // one detector per sync pin
   generate
      for (i = 0; i < cfecr_pkg::NUM_SYNC; i++) begin : g_det
         logic                           prev_r;  // last level
         logic [cfecr_pkg::ACT_CNT_W-1:0] quiet_r; // cycles idle
         logic                           act_r;   // activity flag
         // an edge restarts the quiet count and sets activity
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               prev_r  <= 1'b0;
               quiet_r <= '0;
               act_r   <= 1'b0;
            end else begin
               prev_r <= act.syncLvl[i];
               if (prev_r != act.syncLvl[i]) begin
                  quiet_r <= '0;
                  act_r   <= 1'b1;
               end else if (quiet_r == cfecr_pkg::ACT_CYC) begin
                  act_r <= 1'b0;
               end else begin
                  quiet_r <= quiet_r + 1'b1;
               end
            end
         end
         assign act.active[i] = act_r;
      end
   endgenerate
endmodule // cfecr_act_det

// *** hdl/cfecr_top.sv ***
// Strobed register access was decided locally.
`timescale 1ns/10ps
// control register bank of the capture front end
module cfecr_top (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdata,
   // pins from outside
   input  wire logic [1:0] horizSyncInput,
   input  wire logic [1:0] greenSyncInput,
   input  wire logic       powerDownPin,
   // internal sync processing events, same clock
   input  wire logic       clampPulse,
   input  wire logic       vsyncPulse,
   input  wire logic       regenHsync,
   input  wire logic       filtHsync,
   // slicer output pin
   output logic            slicerOutputPin,
   output logic            slicerOutputPinOe,
   output logic      [4:0] slicerThresh,
   // input control
   output logic            chanSel,
   output logic            bwHigh,
   // power and output control
   output logic            coreSleep,
   output logic            priOe,
   output logic            secOe,
   output logic      [2:0] outFormat,
   output logic      [4:0] dataPinCnt,
   output logic            ddrRgb,
   output logic            blueSecondary,
   // auto-offset loop
   output logic            autoOffsetEn,
   output logic            offsetUpdate
);

   // stored registers
   logic [7:0] offCtl_r;   // offset update control
   logic [7:0] testCfg_r;  // test configuration
   logic [7:0] slcCtl_r;   // slicer control
   logic [7:0] inPwr_r;    // input and power control
   logic [7:0] outFmt_r;   // output format control
   logic [7:0] rdata_r;    // read data register

   // pin synchronisers: h0, h1, sog0, sog1, power-down pin
   logic [4:0] syncA_r;    // first stage, read only by second
   logic [4:0] syncB_r;    // second stage, usable

   // auto-offset loop state
   logic [7:0] aoCnt_r;    // events seen since last update
   logic [7:0] aoTgt;      // events per update
   logic       aoEvt;      // counted event this cycle
   logic       aoPulse_r;  // update strobe

   // channel choice
   logic       autoCh_r;   // automatically chosen channel
   logic       chan_r;     // channel in use

   // power state
   logic       pinAct;     // power-down pin asserted
   logic       pdReq;      // power-down requested
   logic       sleep_r;    // core powered down
   logic       priOe_r;    // primary outputs driven
   logic       secOe_r;    // secondary outputs driven

   // slicer output path
   logic       slcSrc;     // selected source
   logic       slcOut_r;   // pin level
   logic       slcOe_r;    // pin drive enable

   // output format decode
   logic [2:0] fmtCode;    // raw format field
   logic [2:0] fmt_r;      // format in force
   logic [4:0] pins_r;     // data pins in use
   logic       ddr_r;      // rgb on both clock edges
   logic       blue2_r;    // blue pins carry secondary

   // activity detector link
   cfecr_act_if actIf ();
   logic [3:0]  act;       // activity flags

   // activity detector on the synchronised sync pins
   cfecr_act_det u_act (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .act     (actIf.det)
   );
   assign actIf.syncLvl = syncB_r[3:0];
   assign act           = actIf.active;

   // two-stage synchroniser for every pin input
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_r <= 5'h00;
         syncB_r <= 5'h00;
      end else begin
         syncA_r <= {powerDownPin, greenSyncInput, horizSyncInput};
         syncB_r <= syncA_r;
      end
   end

   // register writes; each of the five control offsets is an ordinary store
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         offCtl_r  <= cfecr_pkg::RST_OFFSET;
         testCfg_r <= cfecr_pkg::RST_TEST;
         slcCtl_r  <= cfecr_pkg::RST_SLICER;
         inPwr_r   <= cfecr_pkg::RST_INPWR;
         outFmt_r  <= cfecr_pkg::RST_OUTFMT;
      end else if (regWr) begin
         case (regAddr)
            cfecr_pkg::OFF_OFFSET: begin
               offCtl_r <= regWdata;
            end
            cfecr_pkg::OFF_TEST: begin
               testCfg_r <= regWdata;
            end
            cfecr_pkg::OFF_SLICER: begin
               slcCtl_r <= regWdata;
            end
            cfecr_pkg::OFF_INPWR: begin
               inPwr_r <= regWdata;
            end
            cfecr_pkg::OFF_OUTFMT: begin
               outFmt_r <= regWdata;
            end
            // status and unmapped offsets ignore writes
            default: begin
            end
         endcase
      end
   end

   // read data stand one cycle after the strobe, else zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            cfecr_pkg::OFF_OFFSET: begin
               rdata_r <= offCtl_r;
            end
            cfecr_pkg::OFF_TEST: begin
               rdata_r <= testCfg_r;
            end
            cfecr_pkg::OFF_SLICER: begin
               rdata_r <= slcCtl_r;
            end
            cfecr_pkg::OFF_INPWR: begin
               rdata_r <= inPwr_r;
            end
            cfecr_pkg::OFF_OUTFMT: begin
               rdata_r <= outFmt_r;
            end
            // live activity flags, other bits read zero
            cfecr_pkg::OFF_ACTIV: begin
               rdata_r <= 8'h00;
               rdata_r[cfecr_pkg::ST_H0_BIT] <= act[0];
               rdata_r[cfecr_pkg::ST_H1_BIT] <= act[1];
               rdata_r[cfecr_pkg::ST_S0_BIT] <= act[2];
               rdata_r[cfecr_pkg::ST_S1_BIT] <= act[3];
            end
            // unmapped offsets read zero
            default: begin
               rdata_r <= 8'h00;
            end
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   // events per update and which event is counted
   always_comb begin
      case (offCtl_r[cfecr_pkg::AO_UPD_LSB +: 2])
         cfecr_pkg::UPD_3CLMP: begin
            aoTgt = cfecr_pkg::CNT_3;
            aoEvt = clampPulse;
         end
         cfecr_pkg::UPD_48CLMP: begin
            aoTgt = cfecr_pkg::CNT_48;
            aoEvt = clampPulse;
         end
         cfecr_pkg::UPD_192CLMP: begin
            aoTgt = cfecr_pkg::CNT_192;
            aoEvt = clampPulse;
         end
         // every third vertical sync
         default: begin
            aoTgt = cfecr_pkg::CNT_3;
            aoEvt = vsyncPulse;
         end
      endcase
   end

   // update counter; idle and cleared while auto-offset is off
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aoCnt_r   <= 8'h00;
         aoPulse_r <= 1'b0;
      end else if (!offCtl_r[cfecr_pkg::AO_EN_BIT]) begin
         aoCnt_r   <= 8'h00;
         aoPulse_r <= 1'b0;
      end else if (aoEvt) begin
         // a shortened interval fires on the next counted event, never wraps
         if (aoCnt_r >= aoTgt - 8'h01) begin
            aoCnt_r   <= 8'h00;
            aoPulse_r <= 1'b1;
         end else begin
            aoCnt_r   <= aoCnt_r + 8'h01;
            aoPulse_r <= 1'b0;
         end
      end else begin
         aoPulse_r <= 1'b0;
      end
   end

   // automatic channel: first with any sync activity, else hold
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         autoCh_r <= 1'b0;
      end else if (act[0] | act[2]) begin
         autoCh_r <= 1'b0;
      end else if (act[1] | act[3]) begin
         autoCh_r <= 1'b1;
      end
   end

   // channel in use: override hands the choice to software
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_r <= 1'b0;
      end else if (inPwr_r[cfecr_pkg::IP_OVR_BIT]) begin
         chan_r <= inPwr_r[cfecr_pkg::IP_CHAN_BIT];
      end else begin
         chan_r <= autoCh_r;
      end
   end

   // pin polarity matters only under manual control
   assign pinAct = inPwr_r[cfecr_pkg::IP_PPOL_BIT] ?
                   syncB_r[4] : ~syncB_r[4];

   // power-down request from the selected control source
   always_comb begin
      if (inPwr_r[cfecr_pkg::IP_AUTO_BIT]) begin
         pdReq = ~(|act);
      end else begin
         pdReq = inPwr_r[cfecr_pkg::IP_PD_BIT] | pinAct;
      end
   end

   // core sleep and data output enables
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_r <= 1'b0;
         priOe_r <= 1'b0;
         secOe_r <= 1'b0;
      end else begin
         // fast switching keeps the core awake, outputs still off
         sleep_r <= pdReq & ~inPwr_r[cfecr_pkg::IP_FAST_BIT];
         priOe_r <= outFmt_r[cfecr_pkg::OF_PRI_BIT] & ~pdReq;
         secOe_r <= outFmt_r[cfecr_pkg::OF_SEC_BIT] & ~pdReq;
      end
   end

   // slicer output source for the channel in use
   always_comb begin
      case (slcCtl_r[cfecr_pkg::SL_SEL_LSB +: 2])
         cfecr_pkg::SRC_RAWSOG: begin
            slcSrc = chan_r ? syncB_r[3] : syncB_r[2];
         end
         cfecr_pkg::SRC_RAWHS: begin
            slcSrc = chan_r ? syncB_r[1] : syncB_r[0];
         end
         cfecr_pkg::SRC_REGEN: begin
            slcSrc = regenHsync;
         end
         default: begin
            slcSrc = filtHsync;
         end
      endcase
   end

   // slicer pin level and drive; sources are active-high pulses
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         slcOut_r <= 1'b1;
         slcOe_r  <= 1'b1;
      end else begin
         // negative-going when the polarity bit is clear
         slcOut_r <= slcCtl_r[cfecr_pkg::SL_POL_BIT] ?
                     slcSrc : ~slcSrc;
         slcOe_r  <= ~(pdReq & inPwr_r[cfecr_pkg::IP_TRI_BIT]);
      end
   end

   assign fmtCode = outFmt_r[cfecr_pkg::OF_FMT_LSB +: 3];

   // output format decode; reserved codes behave as 4:4:4 rgb
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fmt_r   <= cfecr_pkg::FMT_444;
         pins_r  <= cfecr_pkg::PINS_FULL;
         ddr_r   <= 1'b0;
         blue2_r <= 1'b0;
      end else begin
         case (fmtCode)
            cfecr_pkg::FMT_422: begin
               fmt_r   <= fmtCode;
               pins_r  <= cfecr_pkg::PINS_422;
               ddr_r   <= 1'b0;
               blue2_r <= 1'b1;
            end
            cfecr_pkg::FMT_DDR: begin
               fmt_r   <= fmtCode;
               pins_r  <= cfecr_pkg::PINS_FULL;
               ddr_r   <= 1'b1;
               blue2_r <= 1'b1;
            end
            default: begin
               fmt_r   <= cfecr_pkg::FMT_444;
               pins_r  <= cfecr_pkg::PINS_FULL;
               ddr_r   <= 1'b0;
               blue2_r <= 1'b0;
            end
         endcase
      end
   end

   // outputs, each straight from a flip-flop
   assign regRdata          = rdata_r;
   assign slicerOutputPin   = slcOut_r;
   assign slicerOutputPinOe = slcOe_r;
   assign slicerThresh      = slcCtl_r[cfecr_pkg::SL_THR_LSB +: 5];
   assign chanSel           = chan_r;
   assign bwHigh            = inPwr_r[cfecr_pkg::IP_BW_BIT];
   assign coreSleep         = sleep_r;
   assign priOe             = priOe_r;
   assign secOe             = secOe_r;
   assign outFormat         = fmt_r;
   assign dataPinCnt        = pins_r;
   assign ddrRgb            = ddr_r;
   assign blueSecondary     = blue2_r;
   assign autoOffsetEn      = offCtl_r[cfecr_pkg::AO_EN_BIT];
   assign offsetUpdate      = aoPulse_r;

endmodule // cfecr_top

// *** include/cfecr_act_if.sv ***
`timescale 1ns/10ps
// carries synchronised sync levels and their activity
interface cfecr_act_if;
   logic [3:0] syncLvl;  // synchronised sync pins
   logic [3:0] active;   // activity seen per pin
   modport src (output syncLvl, input active);
   modport det (input syncLvl, output active);
endinterface // cfecr_act_if

// *** include/cfecr_pkg.sv ***
package cfecr_pkg;
   // register offsets
   localparam logic [7:0] OFF_OFFSET = 8'h1B;
   localparam logic [7:0] OFF_TEST   = 8'h1C;
   localparam logic [7:0] OFF_SLICER = 8'h1D;
   localparam logic [7:0] OFF_INPWR  = 8'h1E;
   localparam logic [7:0] OFF_OUTFMT = 8'h1F;
   localparam logic [7:0] OFF_ACTIV  = 8'h24;
   // reset values
   localparam logic [7:0] RST_OFFSET = 8'h5B;
   localparam logic [7:0] RST_TEST   = 8'hFF;
   localparam logic [7:0] RST_SLICER = 8'h78;
   localparam logic [7:0] RST_INPWR  = 8'h20;
   localparam logic [7:0] RST_OUTFMT = 8'h94;
   // offset update control fields
   localparam int AO_EN_BIT  = 5;
   localparam int AO_UPD_LSB = 3;
   // slicer control fields
   localparam int SL_THR_LSB = 3;
   localparam int SL_POL_BIT = 2;
   localparam int SL_SEL_LSB = 0;
   // input and power control fields
   localparam int IP_OVR_BIT  = 7;
   localparam int IP_CHAN_BIT = 6;
   localparam int IP_BW_BIT   = 5;
   localparam int IP_AUTO_BIT = 4;
   localparam int IP_PD_BIT   = 3;
   localparam int IP_PPOL_BIT = 2;
   localparam int IP_FAST_BIT = 1;
   localparam int IP_TRI_BIT  = 0;
   // output format fields
   localparam int OF_FMT_LSB = 5;
   localparam int OF_PRI_BIT = 4;
   localparam int OF_SEC_BIT = 3;
   // activity status bit positions
   localparam int ST_H0_BIT = 7;
   localparam int ST_H1_BIT = 6;
   localparam int ST_S0_BIT = 3;
   localparam int ST_S1_BIT = 2;
   // update interval codes and event counts
   localparam logic [1:0] UPD_3CLMP   = 2'h0;
   localparam logic [1:0] UPD_48CLMP  = 2'h1;
   localparam logic [1:0] UPD_192CLMP = 2'h2;
   localparam logic [1:0] UPD_3VSYNC  = 2'h3;
   localparam logic [7:0] CNT_3   = 8'h03;
   localparam logic [7:0] CNT_48  = 8'h30;
   localparam logic [7:0] CNT_192 = 8'hC0;
   // slicer output sources
   localparam logic [1:0] SRC_RAWSOG = 2'h0;
   localparam logic [1:0] SRC_RAWHS  = 2'h1;
   localparam logic [1:0] SRC_REGEN  = 2'h2;
   localparam logic [1:0] SRC_FILT   = 2'h3;
   // output format codes and pin counts
   localparam logic [2:0] FMT_444 = 3'h4;
   localparam logic [2:0] FMT_422 = 3'h5;
   localparam logic [2:0] FMT_DDR = 3'h6;
   localparam logic [4:0] PINS_FULL = 5'h1E;
   localparam logic [4:0] PINS_422  = 5'h14;
   // activity timeout: quiet this long clears a bit
   localparam int CLK_MHZ        = 10;
   localparam int ACT_TIMEOUT_US = 100;
   localparam int ACT_CNT_W      = 10;
   localparam logic [ACT_CNT_W-1:0] ACT_CYC =
      ACT_CNT_W'(ACT_TIMEOUT_US * CLK_MHZ);
   // synchronised sync pins: h0, h1, sog0, sog1
   localparam int NUM_SYNC = 4;
endpackage
